// file: logic/bcr_params.svh
/*
 * bcr_params.svh - offsets, field positions, reset values and bus constants
 * for the regulator command and status register slice.
 * assumes: included by its bare name from the design modules and the bench.
 */
`ifndef BCR_PARAMS_SVH
`define BCR_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define BCR_OFF_CH1_VSEL 8'h00
`define BCR_OFF_CH2_VSEL 8'h01
`define BCR_OFF_CH1_CMD 8'h02
`define BCR_OFF_CH2_CMD 8'h03
`define BCR_OFF_STATUS 8'h04

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define BCR_SLEW_MSB 6
`define BCR_SLEW_LSB 4
`define BCR_MODE_MSB 2
`define BCR_MODE_LSB 1
`define BCR_OFF_BIT 0
`define BCR_CMD_WR_MASK 8'h77
`define BCR_CMD_RESET 8'h00
`define BCR_STATUS_RESET 8'h00

// ****************************************************************
// light-load mode codes
// ****************************************************************
`define BCR_MODE_PIN 2'h0
`define BCR_MODE_FIXED 2'h1
`define BCR_MODE_AUTO 2'h2

// ****************************************************************
// serial bus and slew counter
// ****************************************************************
`define BCR_BUS_ADDR_BASE 7'h60
`define BCR_BITS_PER_BYTE 4'h8
`define BCR_STRAP_WAIT 2'h2
`define BCR_SLEW_CNT_W 7

`endif

// file: logic/bcr_pkg.sv
/*
 * bcr_pkg - types shared by the command and status register slice.
 * assumes: bcr_params.svh is on the include path.
 */
package bcr_pkg;

    // ****************************************************************
    // register layouts
    // ****************************************************************
    typedef struct packed {
        logic rsv7;
        logic [2:0] slew;
        logic rsv3;
        logic [1:0] light_load_switch_sel;
        logic output_off;
    } bcr_cmd_t;

    typedef struct packed {
        logic [4:0] rsv;
        logic temp_warn;
        logic channel2_regulation_ok;
        logic channel1_regulation_ok;
    } bcr_status_t;

    // ****************************************************************
    // serial slave states
    // ****************************************************************
    typedef enum logic [3:0] {
        BCR_IDLE,
        BCR_ADDR,
        BCR_ACK_ADDR,
        BCR_REG,
        BCR_ACK_REG,
        BCR_WDATA,
        BCR_ACK_WDATA,
        BCR_RDATA,
        BCR_MACK
    } bcr_state_t;

endpackage : bcr_pkg

// file: logic/bcr_slew_step.sv
/*
 * bcr_slew_step - emits one 10 mV step strobe every 2^code switching cycles.
 * assumes: sw_cycle_in is a one-cycle pulse on core_clk_in, one per switching cycle.
 */
`timescale 1ns/1ns
`include "bcr_params.svh"

module bcr_slew_step #(
    parameter int CNT_W = `BCR_SLEW_CNT_W
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // control
    input wire logic [2:0] slew_code_in,
    input wire logic sw_cycle_in,
    // step strobe
    output logic step_out
);

    logic [CNT_W-1:0] cnt_reg;
    logic step_reg;
    logic [CNT_W-1:0] limit;
    logic at_limit;

    // limit is 2^code - 1 cycles of waiting
    assign limit = CNT_W'((1 << slew_code_in) - 1);
    assign at_limit = (cnt_reg >= limit);

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_reg <= '0;
            step_reg <= 1'b0;
        end else begin
            step_reg <= sw_cycle_in & at_limit;
            if (sw_cycle_in) begin
                cnt_reg <= at_limit ? '0 : cnt_reg + 1'b1;
            end
        end
    end

    assign step_out = step_reg;

endmodule : bcr_slew_step

// file: logic/bcr_regs.sv
/*
 * bcr_regs - serial-bus slave and the command/status registers of a dual
 * step-down regulator: two channel command registers and one status register.
 * assumes: scl/sda are open-drain pins resolved outside; status inputs and pins
 * are asynchronous; sw_cycle pulses come from logic on core_clk_in.
 */
`timescale 1ns/1ns
`include "bcr_params.svh"

module bcr_regs #(
    parameter logic [6:0] BUS_ADDR_BASE = `BCR_BUS_ADDR_BASE
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // address strap
    input wire logic [1:0] addr_strap_in,
    // hardware pins
    input wire logic channel1_hw_enable_pin_in,
    input wire logic channel2_hw_enable_pin_in,
    input wire logic mode_select_pin_in,
    input wire logic current_share_in,
    // analog status
    input wire logic temp_warn_in,
    input wire logic channel1_regulation_ok_in,
    input wire logic channel2_regulation_ok_in,
    // switching cycle pulses
    input wire logic ch1_sw_cycle_in,
    input wire logic ch2_sw_cycle_in,
    // channel controls
    output logic channel1_output_off_out,
    output logic channel2_output_off_out,
    output logic ch1_auto_skip_out,
    output logic ch2_auto_skip_out,
    output logic [2:0] ch1_slew_code_out,
    output logic [2:0] ch2_slew_code_out,
    output logic ch1_slew_step_out,
    output logic ch2_slew_step_out
);

    localparam int NSYNC = 11;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] raw_pins;

    assign raw_pins = {addr_strap_in, channel2_regulation_ok_in, channel1_regulation_ok_in,
                       temp_warn_in, current_share_in, mode_select_pin_in,
                       channel2_hw_enable_pin_in, channel1_hw_enable_pin_in, sda_in, scl_in};

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_reg <= 11'h7FF;
            sync2_reg <= 11'h7FF;
        end else begin
            sync1_reg <= raw_pins;
            sync2_reg <= sync1_reg;
        end
    end

    logic scl_s, sda_s, hw_en_ch1_s, hw_en_ch2_s, mode_pin_s, share_s;
    logic temp_s, pg1_s, pg2_s;
    logic [1:0] strap_s;
    assign {strap_s, pg2_s, pg1_s, temp_s, share_s, mode_pin_s, hw_en_ch2_s, hw_en_ch1_s,
        sda_s, scl_s} = sync2_reg;

    // ****************************************************************
    // address strap, caught once after reset release
    // ****************************************************************
    logic strap_done_reg;
    logic [1:0] strap_wait_reg;
    logic [1:0] strap_reg;
    logic [6:0] my_addr;

    // the sync chain holds its reset ones for two clocks; wait for the real level
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            strap_done_reg <= 1'b0;
            strap_wait_reg <= 2'h0;
            strap_reg <= 2'h0;
        end else if (!strap_done_reg) begin
            if (strap_wait_reg == `BCR_STRAP_WAIT) begin
                strap_done_reg <= 1'b1;
                strap_reg <= strap_s;
            end else begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
        end
    end

    assign my_addr = BUS_ADDR_BASE | {5'h00, strap_reg};

    // ****************************************************************
    // bus edge and condition detection
    // ****************************************************************
    logic scl_d_reg, sda_d_reg;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ****************************************************************
    // serial slave state machine
    // ****************************************************************
    bcr_pkg::bcr_state_t state_reg, state_next;
    logic [3:0] bitcnt_reg, bitcnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic nack_reg, nack_next;
    logic oe_reg, oe_next;
    logic [7:0] rd_data;
    logic byte_done;

    assign byte_done = (bitcnt_reg == `BCR_BITS_PER_BYTE);

    always_comb begin
        state_next = state_reg;
        bitcnt_next = bitcnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        nack_next = nack_reg;
        oe_next = oe_reg;
        if (start_cond) begin
            state_next = bcr_pkg::BCR_ADDR;
            bitcnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (stop_cond) begin
            state_next = bcr_pkg::BCR_IDLE;
            oe_next = 1'b0;
        end else if (scl_rise) begin
            if (state_reg == bcr_pkg::BCR_MACK) begin
                nack_next = sda_s;
            end else if (state_reg == bcr_pkg::BCR_ADDR || state_reg == bcr_pkg::BCR_REG ||
                         state_reg == bcr_pkg::BCR_WDATA) begin
                shift_next = {shift_reg[6:0], sda_s};
                bitcnt_next = bitcnt_reg + 4'h1;
            end
        end else if (scl_fall) begin
            case (state_reg)
                bcr_pkg::BCR_ADDR: begin
                    if (byte_done) begin
                        if (shift_reg[7:1] == my_addr) begin
                            rw_next = shift_reg[0];
                            oe_next = 1'b1;
                            state_next = bcr_pkg::BCR_ACK_ADDR;
                        end else begin
                            state_next = bcr_pkg::BCR_IDLE;
                        end
                    end
                end
                bcr_pkg::BCR_ACK_ADDR: begin
                    bitcnt_next = 4'h0;
                    if (rw_reg) begin
                        tx_next = {rd_data[6:0], 1'b0};
                        oe_next = ~rd_data[7];
                        ptr_next = ptr_reg + 8'h01;
                        bitcnt_next = 4'h1;
                        state_next = bcr_pkg::BCR_RDATA;
                    end else begin
                        oe_next = 1'b0;
                        state_next = bcr_pkg::BCR_REG;
                    end
                end
                bcr_pkg::BCR_REG: begin
                    if (byte_done) begin
                        ptr_next = shift_reg;
                        oe_next = 1'b1;
                        state_next = bcr_pkg::BCR_ACK_REG;
                    end
                end
                bcr_pkg::BCR_WDATA: begin
                    if (byte_done) begin
                        ptr_next = ptr_reg + 8'h01;
                        oe_next = 1'b1;
                        state_next = bcr_pkg::BCR_ACK_WDATA;
                    end
                end
                bcr_pkg::BCR_ACK_REG, bcr_pkg::BCR_ACK_WDATA: begin
                    oe_next = 1'b0;
                    bitcnt_next = 4'h0;
                    state_next = bcr_pkg::BCR_WDATA;
                end
                bcr_pkg::BCR_RDATA: begin
                    if (byte_done) begin
                        oe_next = 1'b0;
                        state_next = bcr_pkg::BCR_MACK;
                    end else begin
                        oe_next = ~tx_reg[7];
                        tx_next = {tx_reg[6:0], 1'b0};
                        bitcnt_next = bitcnt_reg + 4'h1;
                    end
                end
                bcr_pkg::BCR_MACK: begin
                    if (nack_reg) begin
                        state_next = bcr_pkg::BCR_IDLE;
                    end else begin
                        tx_next = {rd_data[6:0], 1'b0};
                        oe_next = ~rd_data[7];
                        ptr_next = ptr_reg + 8'h01;
                        bitcnt_next = 4'h1;
                        state_next = bcr_pkg::BCR_RDATA;
                    end
                end
                default: begin
                    state_next = bcr_pkg::BCR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= bcr_pkg::BCR_IDLE;
            bitcnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            nack_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bitcnt_reg <= bitcnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            nack_reg <= nack_next;
            oe_reg <= oe_next;
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_out = oe_reg;

    // ****************************************************************
    // register file
    // ****************************************************************
    bcr_pkg::bcr_cmd_t cmd1_reg, cmd2_reg;
    bcr_pkg::bcr_status_t status_reg;
    logic hw_shutdown, wr_commit, wr_cmd1, wr_cmd2;
    logic [7:0] wr_val;

    assign hw_shutdown = ~hw_en_ch1_s & ~hw_en_ch2_s;
    // commit on the scl fall that closes the data byte, before the ack
    assign wr_commit = scl_fall & byte_done & (state_reg == bcr_pkg::BCR_WDATA) &
                       ~start_cond & ~stop_cond & ~hw_shutdown;
    assign wr_cmd1 = wr_commit & (ptr_reg == `BCR_OFF_CH1_CMD);
    assign wr_cmd2 = wr_commit & (ptr_reg == `BCR_OFF_CH2_CMD) & ~share_s;
    assign wr_val = shift_reg & `BCR_CMD_WR_MASK;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmd1_reg <= `BCR_CMD_RESET;
            cmd2_reg <= `BCR_CMD_RESET;
            status_reg <= `BCR_STATUS_RESET;
        end else begin
            if (wr_cmd1) begin
                cmd1_reg <= wr_val;
            end
            if (wr_cmd2) begin
                cmd2_reg <= wr_val;
            end
            status_reg <= {5'h00, temp_s, pg2_s, pg1_s};
        end
    end

    // voltage-select registers live elsewhere; here they and unmapped offsets read zero
    assign rd_data = (ptr_reg == `BCR_OFF_CH1_CMD) ? cmd1_reg :
                     (ptr_reg == `BCR_OFF_CH2_CMD) ? cmd2_reg :
                     (ptr_reg == `BCR_OFF_STATUS) ? status_reg : 8'h00;

    // ****************************************************************
    // channel controls
    // ****************************************************************
    bcr_pkg::bcr_cmd_t eff2;
    logic auto1_next, auto2_next;

    assign eff2 = share_s ? cmd1_reg : cmd2_reg;

    function automatic logic bcr_auto_skip(input logic [1:0] sel, input logic pin);
        logic r;
        r = 1'b0;
        if (sel == `BCR_MODE_PIN) begin
            r = pin;
        end else if (sel == `BCR_MODE_AUTO) begin
            r = 1'b1;
        end
        return r;
    endfunction : bcr_auto_skip

    // reserved code 11 falls back to fixed frequency
    assign auto1_next = bcr_auto_skip(cmd1_reg.light_load_switch_sel, mode_pin_s);
    assign auto2_next = bcr_auto_skip(eff2.light_load_switch_sel, mode_pin_s);

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            channel1_output_off_out <= 1'b0;
            channel2_output_off_out <= 1'b0;
            ch1_auto_skip_out <= 1'b0;
            ch2_auto_skip_out <= 1'b0;
            ch1_slew_code_out <= 3'h0;
            ch2_slew_code_out <= 3'h0;
        end else begin
            channel1_output_off_out <= cmd1_reg.output_off;
            channel2_output_off_out <= eff2.output_off;
            ch1_auto_skip_out <= auto1_next;
            ch2_auto_skip_out <= auto2_next;
            ch1_slew_code_out <= cmd1_reg.slew;
            ch2_slew_code_out <= eff2.slew;
        end
    end

    bcr_slew_step u_slew1 (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .slew_code_in(cmd1_reg.slew),
        .sw_cycle_in(ch1_sw_cycle_in),
        .step_out(ch1_slew_step_out)
    );

    bcr_slew_step u_slew2 (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .slew_code_in(eff2.slew),
        .sw_cycle_in(ch2_sw_cycle_in),
        .step_out(ch2_slew_step_out)
    );

endmodule : bcr_regs

// file: sim/bcr_regs_assertions.sv
/* bcr_regs_assertions - port-level checks on the command/status slice.
   assumes: bound to bcr_regs; one clock, async active-high reset. */
`timescale 1ns/1ns
module bcr_regs_assertions (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic channel1_hw_enable_pin_in,
    input wire logic channel2_hw_enable_pin_in,
    input wire logic current_share_in,
    input wire logic ch1_sw_cycle_in,
    input wire logic ch2_sw_cycle_in,
    // channel controls
    input wire logic channel1_output_off_out,
    input wire logic channel2_output_off_out,
    input wire logic ch1_auto_skip_out,
    input wire logic [2:0] ch1_slew_code_out,
    input wire logic [2:0] ch2_slew_code_out,
    input wire logic ch1_slew_step_out,
    input wire logic ch2_slew_step_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    sda_drain_only_a: assert property (sda_out == 1'b0) else $error("sda driven high");
    rst_clear_a: assert property ($fell(sys_rst_in) |-> !sda_oe_out && !ch1_auto_skip_out
        && ch1_slew_code_out == 3'h0 && !channel1_output_off_out) else $error("reset value");
    oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in))
        else $error("sda moved with scl high");
    ch1_step_cause_a: assert property (ch1_slew_step_out |->
        $past(ch1_sw_cycle_in) || $past(ch1_sw_cycle_in, 2)) else $error("ch1 stray step");
    ch2_step_cause_a: assert property (ch2_slew_step_out |->
        $past(ch2_sw_cycle_in) || $past(ch2_sw_cycle_in, 2)) else $error("ch2 stray step");
    ch1_code0_step_a: assert property (ch1_sw_cycle_in && ch1_slew_code_out == 3'h0
        |-> ##[1:2] ch1_slew_step_out) else $error("ch1 code 0 step missing");
    ch2_code0_step_a: assert property (ch2_sw_cycle_in && ch2_slew_code_out == 3'h0
        |-> ##[1:2] ch2_slew_step_out) else $error("ch2 code 0 step missing");
    share_follow_a: assert property (current_share_in [*8] |->
        ch2_slew_code_out == ch1_slew_code_out && channel2_output_off_out ==
        channel1_output_off_out) else $error("ch2 not following ch1");
    hw_off_hold_a: assert property ((!channel1_hw_enable_pin_in &&
        !channel2_hw_enable_pin_in) [*6] |=> $stable(ch1_slew_code_out) &&
        $stable(channel1_output_off_out)) else $error("write landed in shutdown");

    cover property (ch1_slew_step_out && ch1_slew_code_out == 3'h7);
    cover property ($rose(sda_oe_out) && !channel1_hw_enable_pin_in);
    cover property (current_share_in && ch2_slew_step_out);
endmodule : bcr_regs_assertions

// file: sim/bcr_i2c_master.sv
/* bcr_i2c_master - behavioural serial-bus master driving scl and pulling sda.
   assumes: sda_in is the resolved wire with a pull-up; calls begin at a clock edge. */
`timescale 1ns/1ns
module bcr_i2c_master #(
    parameter int HALF = 8
) (
    // clock
    input wire logic core_clk_in,
    // bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out <= 1'b1;
        sda_low_out <= 1'b0;
    end
    task automatic hold();
        repeat (HALF) @(posedge core_clk_in);
    endtask : hold
    // sda only moves with scl low, except in start and stop
    task automatic cond(input logic rise);
        sda_low_out <= rise;
        hold();
        scl_out <= 1'b1;
        hold();
        sda_low_out <= !rise;
        hold();
        scl_out <= rise;
        hold();
    endtask : cond
    task automatic bit_io(input logic b, output logic s);
        sda_low_out <= !b;
        hold();
        scl_out <= 1'b1;
        hold();
        s = sda_in;
        scl_out <= 1'b0;
        hold();
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            q[i] = s;
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask : xfer
    // start, address, register byte, data byte, stop
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, d, output logic ack);
        logic [7:0] q;
        logic k1, k2, k3;
        cond(1'b0);
        xfer({dev, 1'b0}, q, k1);
        xfer(a, q, k2);
        xfer(d, q, k3);
        cond(1'b1);
        ack = k1 && k2 && k3;
    endtask : wr
    // pointer write, repeated start, one byte read and not acknowledged
    task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
        logic [7:0] q;
        logic k;
        cond(1'b0);
        xfer({dev, 1'b0}, q, k);
        xfer(a, q, k);
        cond(1'b0);
        xfer({dev, 1'b1}, q, k);
        xfer(8'hFF, d, k);
        cond(1'b1);
    endtask : rd
endmodule : bcr_i2c_master

// file: sim/tb.sv
/* tb - self-checking bench for the command/status slice behind its bus.
   assumes: bcr_regs, bcr_i2c_master and bcr_regs_assertions compiled first. */
`timescale 1ns/1ns
`include "bcr_params.svh"
module tb;
    logic core_clk_in, sys_rst_in, share, msel, hwe1, hwe2, temp, pg1, pg2, sw1, sw2;
    logic scl, sda_lo, sda_oe, sda_o, off1, off2, as1, as2, st1, st2, ack;
    logic [1:0] strap;
    logic [2:0] code1, code2;
    logic [6:0] dev;
    logic [7:0] d, q, prev;
    int n_errors, check_count;
    wire sda = !(sda_lo || sda_oe);

    bcr_regs bcr_regs_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_strap_in(strap),
        .channel1_hw_enable_pin_in(hwe1), .channel2_hw_enable_pin_in(hwe2),
        .mode_select_pin_in(msel), .current_share_in(share), .temp_warn_in(temp),
        .channel1_regulation_ok_in(pg1), .channel2_regulation_ok_in(pg2),
        .ch1_sw_cycle_in(sw1), .ch2_sw_cycle_in(sw2), .channel1_output_off_out(off1),
        .channel2_output_off_out(off2), .ch1_auto_skip_out(as1), .ch2_auto_skip_out(as2),
        .ch1_slew_code_out(code1), .ch2_slew_code_out(code2), .ch1_slew_step_out(st1),
        .ch2_slew_step_out(st2));
    bcr_i2c_master bcr_i2c_master_i (.core_clk_in(core_clk_in), .sda_in(sda),
        .scl_out(scl), .sda_low_out(sda_lo));

    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    task automatic check(input string name, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // code 11 is reserved and runs fixed frequency
    function automatic logic exp_skip(input logic [1:0] m, input logic pin);
        return m == 2'h2 || (m == 2'h0 && pin);
    endfunction : exp_skip
    // one switching pulse on both channels, reports a channel 1 step
    task automatic pulse(output logic s);
        s = 1'b0;
        sw1 <= 1'b1;
        sw2 <= 1'b1;
        @(posedge core_clk_in);
        sw1 <= 1'b0;
        sw2 <= 1'b0;
        repeat (3) begin
            @(negedge core_clk_in);
            s = s || (st1 === 1'b1);
        end
        @(posedge core_clk_in);
    endtask : pulse

    initial begin : main
        int n, k;
        logic s;
        {share, msel, temp, pg1, pg2, sw1, sw2} <= 7'h00;
        {hwe1, hwe2} <= 2'h3;
        sys_rst_in <= 1'b1;
        void'($urandom(30));
        dev = `BCR_BUS_ADDR_BASE | {5'h00, 2'($urandom)};
        strap <= dev[1:0];
        repeat (10) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        for (int a = 2; a <= 4; a++) begin
            bcr_i2c_master_i.rd(dev, 8'(a), q);
            check("reset value", q, 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            d[2:1] = 2'(i >> 1);
            msel <= 1'($urandom);
            bcr_i2c_master_i.wr(dev, 8'h02 + 8'(i & 1), d, ack);
            check("write ack", ack, 8'h01);
            bcr_i2c_master_i.rd(dev, 8'h02 + 8'(i & 1), q);
            check("command readback", q, d & 8'h77);
            check("output off", i[0] ? off2 : off1, d[0]);
            check("slew code", i[0] ? code2 : code1, d[6:4]);
            check("auto skip", i[0] ? as2 : as1, exp_skip(d[2:1], msel));
        end
        for (int i = 0; i < 8; i++) begin
            {temp, pg2, pg1} <= 3'(i);
            bcr_i2c_master_i.wr(dev, 8'h04, 8'hFF, ack);
            bcr_i2c_master_i.rd(dev, 8'h04, q);
            check("status", q, {5'h00, 3'(i)});
        end
        bcr_i2c_master_i.wr(dev, 8'h07, 8'hA5, ack);
        bcr_i2c_master_i.rd(dev, 8'h07, q);
        check("unmapped read", q, 8'h00);
        bcr_i2c_master_i.wr(dev ^ 7'h04, 8'h02, 8'h00, ack);
        check("foreign address ack", ack, 8'h00);
        bcr_i2c_master_i.rd(dev, 8'h02, prev);
        {hwe1, hwe2} <= 2'h0;
        bcr_i2c_master_i.wr(dev, 8'h02, ~prev & 8'h77, ack);
        check("shutdown ack", ack, 8'h01);
        bcr_i2c_master_i.rd(dev, 8'h02, q);
        check("shutdown hold", q, prev);
        hwe2 <= 1'b1;
        bcr_i2c_master_i.wr(dev, 8'h02, 8'h31, ack);
        bcr_i2c_master_i.rd(dev, 8'h02, q);
        check("one enable write", q, 8'h31);
        hwe1 <= 1'b1;
        bcr_i2c_master_i.rd(dev, 8'h03, prev);
        share <= 1'b1;
        bcr_i2c_master_i.wr(dev, 8'h03, ~prev & 8'h77, ack);
        bcr_i2c_master_i.rd(dev, 8'h03, q);
        check("shared ch2 hold", q, prev);
        check("shared ch2 code", code2, 8'h03);
        check("shared ch2 off", off2, 8'h01);
        repeat (8) pulse(s);
        share <= 1'b0;
        bcr_i2c_master_i.wr(dev, 8'h03, 8'h00, ack);
        for (int c = 0; c < 8; c++) begin
            bcr_i2c_master_i.wr(dev, 8'h02, 8'(c << 4) | 8'h02, ack);
            n = 0;
            k = 0;
            s = 1'b0;
            while (!s && k < 300) begin
                pulse(s);
                k++;
            end
            s = 1'b0;
            while (!s && n < 300) begin
                pulse(s);
                n++;
            end
            check("step spacing", 8'(n), 8'(1 << c));
            if (k == 300 || n == 300) begin
                n_errors++;
                break;
            end
        end
        end_sim();
    end
endmodule : tb

bind bcr_regs bcr_regs_assertions bcr_regs_assertions_i (.core_clk_in, .sys_rst_in, .scl_in,
    .sda_out, .sda_oe_out, .channel1_hw_enable_pin_in, .channel2_hw_enable_pin_in,
    .current_share_in, .ch1_sw_cycle_in, .ch2_sw_cycle_in, .channel1_output_off_out,
    .channel2_output_off_out, .ch1_auto_skip_out, .ch1_slew_code_out, .ch2_slew_code_out,
    .ch1_slew_step_out, .ch2_slew_step_out);
